// ==== gl_bus_glue.sv ====
// Notes on behaviour
// - on dma need, assert bus request and wait for grant before bus activity
// - take bus by driving grant ack once strobe, port acks, grant ack idle
// - bus request withdrawn as soon as grant ack is asserted
// - owned bus runs three-clock dma cycles on the board clock, S2 stretched one clock per port wait state
// - space code 1, size 0, address 0 driven low only while grant ack
// - master cycles only use data spaces 001 or 101
// - space code 2 comes from user output bit 0, user or supervisor
// - size bit 1 comes from user output bit 1, software keeps it 0
// - user output bits change with the address lines
// - rom select and ack drivers enabled by strobe and address decode with A8 high
// - rom ack drives bit 0 low, bit 1 high; otherwise released
// - mac chip select uses the same decode with A8 low
// - rom select and rom acks released when the host ends the cycle
// - carrier indicator is inverse of carrier sense
// - transmit and collision indicators are inverses of their sources
// - no local packet memory, all data moves through master cycles
`timescale 1ns/10ps
`default_nettype none
`include "gl_bus_regs.svh"

module gl_bus_glue (
    input wire logic CLK,
    input wire logic RST_N,
    input wire gl_pkg::gl_dma_req_t DMA_REQ,
    output logic DMA_READY,
    output logic [31:0] DMA_RDATA,
    input wire logic USER_OUT_BIT_0,
    input wire logic USER_OUT_BIT_1,
    output logic BUS_REQUEST_N,
    input wire logic BUS_GRANT_N,
    input wire logic GRANT_ACKNOWLEDGE_N_I,
    output logic GRANT_ACKNOWLEDGE_N_O,
    output logic GRANT_ACKNOWLEDGE_N_OE_N,
    input wire logic ADDRESS_STROBE_N_I,
    output logic ADDRESS_STROBE_N_O,
    output logic DATA_STROBE_N_O,
    output logic READ_WRITE_N_O,
    output logic CTRL_OE_N,
    input wire logic PORT_ACK_0_N,
    input wire logic PORT_ACK_1_N,
    input wire logic [31:0] ADDR_I,
    output logic [31:0] ADDR_O,
    input wire logic [31:0] DATA_I,
    output logic [31:0] DATA_O,
    output logic DATA_OE_N,
    output logic SPACE_CODE_2_O,
    output logic TRANSFER_SIZE_1_O,
    output logic SPACE_CODE_1_O,
    output logic TRANSFER_SIZE_0_O,
    output logic ADDR0_O,
    output logic GLUE_OE_N,
    output logic ROM_SELECT_N,
    output logic MAC_CHIP_SELECT_N,
    output logic ROM_ACK_0_O,
    output logic ROM_ACK_1_O,
    output logic ROM_ACK_OE_N,
    input wire gl_pkg::gl_led_t LED_SRC,
    output gl_pkg::gl_led_t LED_OUT
);

    gl_pkg::gl_arb_t arb, next_arb;
    gl_pkg::gl_cyc_t cyc, next_cyc;
    logic br_n, next_br_n;
    logic gack_oe_n, next_gack_oe_n;
    logic as_n, next_as_n;
    logic ds_n, next_ds_n;
    logic rw_n, next_rw_n;
    logic dat_oe_n, next_dat_oe_n;
    logic [31:0] addr, next_addr;
    logic [31:0] wdata, next_wdata;
    logic [31:0] rdata, next_rdata;
    logic ubit0, next_ubit0;
    logic ubit1, next_ubit1;
    logic bus_idle;
    logic port_ack;
    logic board_hit;
    logic rom_hit;
    logic mac_hit;

    assign bus_idle = ADDRESS_STROBE_N_I & PORT_ACK_0_N & PORT_ACK_1_N & GRANT_ACKNOWLEDGE_N_I;
    assign port_ack = ~PORT_ACK_0_N | ~PORT_ACK_1_N;

    // arbitration: request, wait for grant, then wait for a quiet bus
    always_comb begin
        next_arb = arb;
        next_br_n = br_n;
        next_gack_oe_n = gack_oe_n;
        unique case (arb)
            gl_pkg::A_IDLE: begin
                if (DMA_REQ.valid) begin
                    next_arb = gl_pkg::A_REQ;
                    next_br_n = 1'h0;
                end
            end
            gl_pkg::A_REQ: begin
                if (!BUS_GRANT_N) begin
                    next_arb = gl_pkg::A_WAIT;
                end
            end
            gl_pkg::A_WAIT: begin
                // a previous owner may still be finishing its cycle
                if (bus_idle) begin
                    next_arb = gl_pkg::A_OWN;
                    next_gack_oe_n = 1'h0;
                    next_br_n = 1'h1;
                end
            end
            gl_pkg::A_OWN: begin
                // hold the bus across back-to-back requests
                if (!DMA_REQ.valid && cyc == gl_pkg::C_IDLE) begin
                    next_arb = gl_pkg::A_IDLE;
                    next_gack_oe_n = `GL_RST_OE_N;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            arb <= gl_pkg::A_IDLE;
            br_n <= `GL_RST_REQ_N;
            gack_oe_n <= `GL_RST_OE_N;
        end else begin
            arb <= next_arb;
            br_n <= next_br_n;
            gack_oe_n <= next_gack_oe_n;
        end
    end

    // master cycle: S1 strobes, S2 waits for port ack, S3 ends
    always_comb begin
        next_cyc = cyc;
        next_as_n = as_n;
        next_ds_n = ds_n;
        next_rw_n = rw_n;
        next_dat_oe_n = dat_oe_n;
        next_addr = addr;
        next_wdata = wdata;
        next_rdata = rdata;
        next_ubit0 = ubit0;
        next_ubit1 = ubit1;
        unique case (cyc)
            gl_pkg::C_IDLE: begin
                if (arb == gl_pkg::A_OWN && DMA_REQ.valid) begin
                    next_cyc = gl_pkg::C_S1;
                    next_addr = DMA_REQ.addr;
                    next_wdata = DMA_REQ.data;
                    next_rw_n = ~DMA_REQ.write;
                    next_dat_oe_n = ~DMA_REQ.write;
                    // launched on the same edge as the address
                    next_ubit0 = USER_OUT_BIT_0;
                    next_ubit1 = USER_OUT_BIT_1;
                    next_as_n = 1'h0;
                    next_ds_n = 1'h0;
                end
            end
            gl_pkg::C_S1: begin
                next_cyc = gl_pkg::C_S2;
            end
            gl_pkg::C_S2: begin
                // slow ports simply stretch this state
                if (port_ack) begin
                    next_cyc = gl_pkg::C_S3;
                    next_rdata = DATA_I;
                    next_as_n = `GL_RST_STROBE_N;
                    next_ds_n = `GL_RST_STROBE_N;
                    next_dat_oe_n = `GL_RST_OE_N;
                end
            end
            gl_pkg::C_S3: begin
                next_cyc = gl_pkg::C_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cyc <= gl_pkg::C_IDLE;
            as_n <= `GL_RST_STROBE_N;
            ds_n <= `GL_RST_STROBE_N;
            rw_n <= `GL_RST_RW_N;
            dat_oe_n <= `GL_RST_OE_N;
            addr <= `GL_RST_WORD;
            wdata <= `GL_RST_WORD;
            rdata <= `GL_RST_WORD;
            ubit0 <= `GL_RST_BIT;
            ubit1 <= `GL_RST_BIT;
        end else begin
            cyc <= next_cyc;
            as_n <= next_as_n;
            ds_n <= next_ds_n;
            rw_n <= next_rw_n;
            dat_oe_n <= next_dat_oe_n;
            addr <= next_addr;
            wdata <= next_wdata;
            rdata <= next_rdata;
            ubit0 <= next_ubit0;
            ubit1 <= next_ubit1;
        end
    end

    // owned-bus outputs from flip-flops, except the grant ack level tied low and ready decoded from the cycle state
    assign BUS_REQUEST_N = br_n;
    assign GRANT_ACKNOWLEDGE_N_O = `GL_DRIVE_LOW;
    assign GRANT_ACKNOWLEDGE_N_OE_N = gack_oe_n;
    assign CTRL_OE_N = gack_oe_n;
    assign ADDRESS_STROBE_N_O = as_n;
    assign DATA_STROBE_N_O = ds_n;
    assign READ_WRITE_N_O = rw_n;
    assign ADDR_O = addr;
    assign DATA_O = wdata;
    assign DATA_OE_N = dat_oe_n;
    assign DMA_RDATA = rdata;
    assign DMA_READY = (cyc == gl_pkg::C_S3);
    assign SPACE_CODE_2_O = ubit0;
    assign TRANSFER_SIZE_1_O = ubit1;

    // glue drivers follow the grant-ack pin, so no clock delay
    assign SPACE_CODE_1_O = `GL_DRIVE_LOW;
    assign TRANSFER_SIZE_0_O = `GL_DRIVE_LOW;
    assign ADDR0_O = `GL_DRIVE_LOW;
    assign GLUE_OE_N = GRANT_ACKNOWLEDGE_N_I;

    // slave decode; strobe release ends it in the same instant
    assign board_hit = (ADDR_I[`GL_DEC_HI:`GL_DEC_LO] == `GL_DEC_PAT) & ~ADDRESS_STROBE_N_I;
    assign rom_hit = board_hit & ADDR_I[`GL_DEC_SPLIT];
    assign mac_hit = board_hit & ~ADDR_I[`GL_DEC_SPLIT];
    assign ROM_SELECT_N = ~rom_hit;
    assign MAC_CHIP_SELECT_N = ~mac_hit;
    assign ROM_ACK_0_O = `GL_ROM_ACK0_LVL;
    assign ROM_ACK_1_O = `GL_ROM_ACK1_LVL;
    assign ROM_ACK_OE_N = ~rom_hit;

    // indicators are plain inversions of the codec lines
    localparam int LEDS = 3;
    logic [LEDS-1:0] led_src_v;
    logic [LEDS-1:0] led_out_v;
    assign led_src_v = LED_SRC;
    generate
        for (genvar i = 0; i < LEDS; i++) begin : g_led
            assign led_out_v[i] = ~led_src_v[i];
        end
    endgenerate
    assign LED_OUT = led_out_v;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_wait_grant;
        !BUS_REQUEST_N && BUS_GRANT_N && arb == gl_pkg::A_REQ |=> GRANT_ACKNOWLEDGE_N_OE_N;
    endproperty
    a_wait_grant: assert property (p_wait_grant) else $error("ack before grant");

    property p_take_quiet;
        $fell(GRANT_ACKNOWLEDGE_N_OE_N) |-> $past(bus_idle) && $past(!BUS_GRANT_N);
    endproperty
    a_take_quiet: assert property (p_take_quiet) else $error("bus taken while busy");

    property p_drop_req;
        !GRANT_ACKNOWLEDGE_N_OE_N |-> BUS_REQUEST_N;
    endproperty
    a_drop_req: assert property (p_drop_req) else $error("request kept with ack");

    property p_three_clk;
        cyc == gl_pkg::C_S1 ##1 port_ack |=> DMA_READY ##1 !DMA_READY;
    endproperty
    a_three_clk: assert property (p_three_clk) else $error("cycle not three clocks");

    property p_glue_en;
        GLUE_OE_N == GRANT_ACKNOWLEDGE_N_I && !SPACE_CODE_1_O && !TRANSFER_SIZE_0_O && !ADDR0_O;
    endproperty
    a_glue_en: assert property (p_glue_en) else $error("glue drivers wrong");

    property p_user_bits;
        $rose(cyc == gl_pkg::C_S1) |-> SPACE_CODE_2_O == $past(USER_OUT_BIT_0)
            && TRANSFER_SIZE_1_O == $past(USER_OUT_BIT_1) && ADDR_O == $past(DMA_REQ.addr);
    endproperty
    a_user_bits: assert property (p_user_bits) else $error("user bits off timing");

    property p_rom_dec;
        !ADDRESS_STROBE_N_I && ADDR_I[`GL_DEC_HI:`GL_DEC_LO] == `GL_DEC_PAT && ADDR_I[`GL_DEC_SPLIT]
            |-> !ROM_SELECT_N && !ROM_ACK_OE_N && !ROM_ACK_0_O && ROM_ACK_1_O && MAC_CHIP_SELECT_N;
    endproperty
    a_rom_dec: assert property (p_rom_dec) else $error("rom decode wrong");

    property p_mac_dec;
        !MAC_CHIP_SELECT_N == (!ADDRESS_STROBE_N_I && ADDR_I[`GL_DEC_HI:`GL_DEC_LO] == `GL_DEC_PAT
            && !ADDR_I[`GL_DEC_SPLIT]);
    endproperty
    a_mac_dec: assert property (p_mac_dec) else $error("mac select wrong");

    property p_rom_end;
        ADDRESS_STROBE_N_I |-> ROM_SELECT_N && ROM_ACK_OE_N;
    endproperty
    a_rom_end: assert property (p_rom_end) else $error("rom held after cycle");

    property p_leds;
        LED_OUT == ~LED_SRC;
    endproperty
    a_leds: assert property (p_leds) else $error("indicator not inverted");

    c_own: cover property (arb == gl_pkg::A_WAIT ##1 arb == gl_pkg::A_OWN);
    c_cycle: cover property (cyc == gl_pkg::C_S1 ##1 port_ack ##1 DMA_READY);
    c_rom: cover property (!ROM_SELECT_N ##1 ROM_SELECT_N);
    c_mac: cover property (!MAC_CHIP_SELECT_N);

endmodule
`default_nettype wire

// ==== gl_bus_regs.svh ====
`ifndef GL_BUS_REGS_SVH
`define GL_BUS_REGS_SVH

// board decode: A31..A24 pattern and the bit that splits rom from mac
`define GL_DEC_HI 31
`define GL_DEC_LO 24
`define GL_DEC_PAT 8'hF9
`define GL_DEC_SPLIT 8

// fixed levels of the generated bus signals
`define GL_DRIVE_LOW 1'h0
`define GL_ROM_ACK0_LVL 1'h0
`define GL_ROM_ACK1_LVL 1'h1

// reset values of owned controls
`define GL_RST_REQ_N 1'h1
`define GL_RST_OE_N 1'h1
`define GL_RST_STROBE_N 1'h1
`define GL_RST_WORD 32'h0
`define GL_RST_RW_N 1'h1
`define GL_RST_BIT 1'h0

`endif

// ==== gl_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module gl_host_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_n,
    input wire logic strobe_n,
    input wire logic write,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] waits,
    output logic grant_n,
    output logic ack_n,
    output logic [31:0] rdata,
    output logic [31:0] last_wd
);
    logic [3:0] cnt;

    // arbiter grants any pending request, even while its own strobe is still low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            grant_n <= 1'h1;
            ack_n <= 1'h1;
            cnt <= 4'h0;
            rdata <= 32'h0;
            last_wd <= 32'h0;
        end else begin
            grant_n <= req_n;
            rdata <= ~rdata; // released data bus never keeps a usable value
            if (strobe_n) begin
                cnt <= 4'h0;
                ack_n <= 1'h1;
            end else begin
                cnt <= cnt + 4'h1;
                // memory answers as a 32-bit port after the chosen wait states
                if (cnt == waits) begin
                    ack_n <= 1'h0;
                    rdata <= ~addr;
                    if (write) begin
                        last_wd <= wdata;
                    end
                end
            end
        end
    end
endmodule

`default_nettype wire

// ==== gl_pkg.sv ====
package gl_pkg;

    typedef enum logic [3:0] {
        A_IDLE = 4'h1,
        A_REQ = 4'h2,
        A_WAIT = 4'h4,
        A_OWN = 4'h8
    } gl_arb_t;

    typedef enum logic [3:0] {
        C_IDLE = 4'h1,
        C_S1 = 4'h2,
        C_S2 = 4'h4,
        C_S3 = 4'h8
    } gl_cyc_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] data;
    } gl_dma_req_t;

    typedef struct packed {
        logic carrier;
        logic transmit;
        logic collision;
    } gl_led_t;

endpackage

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end

module tb_top;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    gl_pkg::gl_dma_req_t req = '0;
    gl_pkg::gl_led_t led = '0;
    gl_pkg::gl_led_t led_out;
    logic ub0 = 1'h0;
    logic ub1 = 1'h0;
    logic host_as = 1'h1;
    logic [31:0] host_addr = 32'h0;
    logic [3:0] waits = 4'h0;
    int error_cnt = 0;
    int checked = 0;
    logic ready, br_n, grant_n, gk_o, gk_oe_n, as_o, rw_n, ctrl_oe_n, ack_n, ds_o, dat_oe_n;
    logic sc2, ts1, sc1, ts0, a0, glue_oe_n, rom_n, mac_n, rk0, rk1, rk_oe_n;
    logic [31:0] rdata_o, addr_o, data_o, rdata, last_wd;
    // wire levels: pulled-up grant ack, strobe and address from whoever owns the bus
    wire logic gack_w = gk_oe_n ? 1'h1 : gk_o;
    wire logic as_w = ctrl_oe_n ? host_as : as_o;
    wire logic [31:0] addr_w = ctrl_oe_n ? host_addr : addr_o;
    wire logic card_as_n = ctrl_oe_n | as_o;

    always #50 clk = ~clk;

    gl_bus_glue u_dut (.CLK(clk), .RST_N(rst_n), .DMA_REQ(req), .DMA_READY(ready),
        .DMA_RDATA(rdata_o), .USER_OUT_BIT_0(ub0), .USER_OUT_BIT_1(ub1),
        .BUS_REQUEST_N(br_n), .BUS_GRANT_N(grant_n), .GRANT_ACKNOWLEDGE_N_I(gack_w),
        .GRANT_ACKNOWLEDGE_N_O(gk_o), .GRANT_ACKNOWLEDGE_N_OE_N(gk_oe_n),
        .ADDRESS_STROBE_N_I(as_w), .ADDRESS_STROBE_N_O(as_o), .DATA_STROBE_N_O(ds_o),
        .READ_WRITE_N_O(rw_n), .CTRL_OE_N(ctrl_oe_n), .PORT_ACK_0_N(ack_n),
        .PORT_ACK_1_N(ack_n), .ADDR_I(addr_w), .ADDR_O(addr_o), .DATA_I(rdata),
        .DATA_O(data_o), .DATA_OE_N(dat_oe_n), .SPACE_CODE_2_O(sc2), .TRANSFER_SIZE_1_O(ts1),
        .SPACE_CODE_1_O(sc1), .TRANSFER_SIZE_0_O(ts0), .ADDR0_O(a0), .GLUE_OE_N(glue_oe_n),
        .ROM_SELECT_N(rom_n), .MAC_CHIP_SELECT_N(mac_n), .ROM_ACK_0_O(rk0),
        .ROM_ACK_1_O(rk1), .ROM_ACK_OE_N(rk_oe_n), .LED_SRC(led), .LED_OUT(led_out));

    gl_host_model u_host (.clk(clk), .rst_n(rst_n), .req_n(br_n), .strobe_n(card_as_n),
        .write(~rw_n), .addr(addr_o), .wdata(data_o), .waits(waits), .grant_n(grant_n),
        .ack_n(ack_n), .rdata(rdata), .last_wd(last_wd));

    task tally_and_finish;
        $display("errors=%0d checks=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // reset levels first, then every indicator source pattern
    task automatic led_sweep;
        `CHK({br_n, gk_oe_n, ctrl_oe_n, as_o, ready}, 5'h1E)
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            led <= gl_pkg::gl_led_t'(i[2:0]);
            @(negedge clk);
            `CHK(led_out, 3'(~i))
        end
    endtask

    // host slave access: decode settles in the same cycle as the address
    task automatic dec(input logic [31:0] a, input logic as, rom, mac);
        @(posedge clk);
        host_addr <= a;
        host_as <= as;
        @(negedge clk);
        `CHK({rom_n, rk_oe_n}, {~rom, ~rom})
        `CHK(mac_n, ~mac)
        if (rom)
            `CHK({rk0, rk1}, 2'h1)
    endtask

    // one master word: arbitration, ownership, cycle timing and data
    task automatic dma(input logic w, input logic [31:0] a, d, input logic u0, u1,
                       input logic [3:0] wt, input logic hold);
        int n;
        n = 0;
        @(posedge clk);
        ub0 <= u0;
        ub1 <= u1;
        waits <= wt;
        host_addr <= 32'h1000_0000;
        host_as <= ~hold;
        req <= '{1'h1, w, a, d};
        while (br_n !== 1'h0 && n < 9) begin
            @(negedge clk);
            n++;
        end
        `CHK({br_n, gk_oe_n, ctrl_oe_n}, 3'h3)
        if (hold) begin
            repeat (6) @(negedge clk);
            `CHK(gk_oe_n, 1'h1)
            @(posedge clk);
            host_as <= 1'h1;
        end
        while (ctrl_oe_n !== 1'h0 && n < 30) begin
            @(negedge clk);
            n++;
        end
        `CHK({gk_oe_n, br_n}, 2'h1)
        `CHK({glue_oe_n, sc1, ts0, a0}, 4'h0)
        while (as_o !== 1'h0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        `CHK({sc2, sc1}, {u0, 1'h0})
        `CHK({ts1, addr_o}, {u1, a})
        `CHK({ds_o, dat_oe_n, rw_n}, {1'h0, ~w, ~w})
        n = 1;
        while (ready !== 1'h1 && n < 30) begin
            @(negedge clk);
            n++;
        end
        `CHK(n, 3 + int'(wt))
        if (w)
            `CHK(last_wd, d)
        else
            `CHK(rdata_o, ~a)
        @(posedge clk);
        req.valid <= 1'h0;
        repeat (3) @(negedge clk);
        `CHK({gk_oe_n, glue_oe_n}, 2'h3)
        `CHK({as_o, ds_o, dat_oe_n}, 3'h7)
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        led_sweep;
        dec(32'hF9FF_FF00, 1'h0, 1'h1, 1'h0);
        dec(32'hF9FF_FF00, 1'h1, 1'h0, 1'h0);
        dec(32'hF9FF_FEFC, 1'h0, 1'h0, 1'h1);
        dec(32'hF8FF_FF00, 1'h0, 1'h0, 1'h0);
        dec(32'hFBFF_FF00, 1'h0, 1'h0, 1'h0);
        dec(32'h79FF_FE00, 1'h0, 1'h0, 1'h0);
        dma(1'h0, 32'h0040_0010, 32'h0, 1'h0, 1'h0, 4'h0, 1'h0);
        dma(1'h1, 32'h0040_0014, 32'hC3A5_5A3C, 1'h1, 1'h0, 4'h2, 1'h0);
        dma(1'h0, 32'h0080_0100, 32'h0, 1'h1, 1'h0, 4'h1, 1'h1);
        tally_and_finish;
    end

    // watchdog at 3000 cycles, well beyond the fewer than a hundred cycles the sequence needs
    initial begin
        #(3000 * 100);
        error_cnt++;
        tally_and_finish;
    end
endmodule

`default_nettype wire
